// *** include/dcf_link_if.sv ***
// link between the fifo cell and the user logic driving it
`default_nettype none

interface dcf_link_if;
   import dcf_pkg::*;

   logic              wr_side_clk;
   logic              rd_side_clk;
   logic              wr_block_sel_n;
   logic              wr_strobe_n;
   logic [DATA_W-1:0] wr_data_in;
   logic              rd_block_sel_n;
   logic              rd_strobe_n;
   logic              fifo_reset_n;
   logic              full;
   logic              empty;
   logic              level_equal_flag;
   logic              level_reached_flag;
   logic [DATA_W-1:0] rd_data_out;
   logic              rd_parity_err;
   logic              wr_parity_err;

   modport dev (
      input  wr_side_clk, rd_side_clk, wr_block_sel_n, wr_strobe_n, wr_data_in,
      input  rd_block_sel_n, rd_strobe_n, fifo_reset_n,
      output full, empty, level_equal_flag, level_reached_flag,
      output rd_data_out, rd_parity_err, wr_parity_err
   );

   modport user (
      output wr_side_clk, rd_side_clk, wr_block_sel_n, wr_strobe_n, wr_data_in,
      output rd_block_sel_n, rd_strobe_n, fifo_reset_n,
      input  full, empty, level_equal_flag, level_reached_flag,
      input  rd_data_out, rd_parity_err, wr_parity_err
   );
endinterface

`default_nettype wire

// *** include/dcf_pkg.sv ***
// constants shared by both ends of the strobe-clocked fifo link
//
// Behaviour
// - writes ignored while full flag set
// - reads ignored while empty flag set
// - reset: empty, counters cleared, outputs zero
// - pointer reset input is active low
// - depth is two to (field plus one)
// - equal and at-or-above level flags
// - level eight bits; wide depths step two
// - wide depth: equal at twice (level plus one)
// - odd parity when select high, else even
// - generation replaces ninth written bit
// - writer drives select, strobe low; rising sample
// - reader drives select, strobe low on read clock
// - write side on write clock, read on read
// - flags update after strobe clock falls
// - user avoids flags in update window
// - user avoids writes leaving full, reads leaving empty
`default_nettype none

package dcf_pkg;
   // ----------------------------------------------------------------
   // data and geometry
   // ----------------------------------------------------------------
   localparam int DATA_W      = 9;
   localparam int PAR_BIT     = 8;
   localparam int DEPTH_LOG_W = 3;
   localparam int LEVEL_W     = 8;
   localparam int WIDE_LOG    = 8;   // depth field value that gives 512 words

   // ----------------------------------------------------------------
   // controller register port
   // ----------------------------------------------------------------
   localparam int REG_AW = 4;
   localparam int REG_DW = 16;

   localparam logic [REG_AW-1:0] OFS_CTRL     = 4'h0;
   localparam logic [REG_AW-1:0] OFS_WDATA    = 4'h1;
   localparam logic [REG_AW-1:0] OFS_RDATA    = 4'h2;
   localparam logic [REG_AW-1:0] OFS_STATUS   = 4'h3;
   localparam logic [REG_AW-1:0] OFS_IRQ_STAT = 4'h4;
   localparam logic [REG_AW-1:0] OFS_IRQ_MASK = 4'h5;

   localparam int CTRL_WR_GO = 0;
   localparam int CTRL_RD_GO = 1;
   localparam int CTRL_PRST  = 2;

   localparam int ST_FULL  = 0;
   localparam int ST_EMPTY = 1;
   localparam int ST_EQ    = 2;
   localparam int ST_GE    = 3;
   localparam int ST_RPE   = 4;
   localparam int ST_WPE   = 5;
   localparam int ST_WBUSY = 6;
   localparam int ST_RBUSY = 7;

   localparam int IRQ_W       = 4;
   localparam int IRQ_WR_DONE = 0;
   localparam int IRQ_RD_DONE = 1;
   localparam int IRQ_RD_PAR  = 2;
   localparam int IRQ_FULL    = 3;

   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // ----------------------------------------------------------------
   // strobe clock timing
   // ----------------------------------------------------------------
   localparam int LINK_HALF_CYC = 4;   // clk_i cycles per strobe clock phase, at least 2

   typedef enum logic [2:0] {
      DCF_IDLE = 3'b001,
      DCF_WR   = 3'b010,
      DCF_RD   = 3'b100
   } dcf_state_t;
endpackage

`default_nettype wire

// *** logic/dcf_fifo_dev.sv ***
// fifo memory cell with strobe clocks, level flags and parity
`default_nettype none

module dcf_fifo_dev
   import dcf_pkg::*;
#(
   parameter int DLW = dcf_pkg::DEPTH_LOG_W
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // link to user logic
   dcf_link_if.dev               link,
   // static configuration
   input  wire logic [DLW-1:0]   depth_log_sel_i,
   input  wire logic [dcf_pkg::LEVEL_W-1:0] level_i,
   input  wire logic             parity_gen_en_i,
   input  wire logic             odd_parity_sel_i
);
   import dcf_pkg::*;

   localparam int AW = 2 ** DLW;
   localparam int CW = AW + 1;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic par_of(input logic [PAR_BIT-1:0] d, input logic odd);
      par_of = (^d) ^ odd;
   endfunction

   function automatic logic [CW-1:0] depth_of(input logic [DLW-1:0] lg);
      depth_of = {{(CW-1){1'b0}}, 1'b1} << (32'(lg) + 1);
   endfunction

   function automatic logic [CW-1:0] level_tgt(input logic [DLW-1:0] lg, input logic [LEVEL_W-1:0] lv);
      if (32'(lg) >= WIDE_LOG) begin
         level_tgt = CW'({1'b0, lv, 1'b0} + 10'h002);
      end else begin
         level_tgt = CW'(lv);
      end
   endfunction

   // ----------------------------------------------------------------
   // strobe clock edges
   // ----------------------------------------------------------------
   logic wclk_q;
   logic rclk_q;
   logic wr_rise;
   logic wr_fall;
   logic rd_rise;
   logic rd_fall;
   logic rst;

   assign rst     = reset_i | ~link.fifo_reset_n;
   assign wr_rise = link.wr_side_clk & ~wclk_q;
   assign wr_fall = ~link.wr_side_clk & wclk_q;
   assign rd_rise = link.rd_side_clk & ~rclk_q;
   assign rd_fall = ~link.rd_side_clk & rclk_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wclk_q <= 1'b0;
         rclk_q <= 1'b0;
      end else begin
         wclk_q <= link.wr_side_clk;
         rclk_q <= link.rd_side_clk;
      end
   end

   // ----------------------------------------------------------------
   // accept logic
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem_q [2**AW];
   logic [AW-1:0]     wptr_q;
   logic [AW-1:0]     rptr_q;
   logic [CW-1:0]     cnt_q;
   logic [CW-1:0]     depth;
   logic [AW-1:0]     ptr_mask;
   logic              full_q;
   logic              empty_q;
   logic              wr_req;
   logic              rd_req;
   logic              wr_acc;
   logic              rd_acc;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rword;

   assign depth    = depth_of(depth_log_sel_i);
   assign ptr_mask = AW'(depth - CW'(1));
   assign wr_req   = wr_rise & ~link.wr_block_sel_n & ~link.wr_strobe_n;
   assign rd_req   = rd_rise & ~link.rd_block_sel_n & ~link.rd_strobe_n;
   assign wr_acc   = wr_req & ~full_q & (cnt_q != depth);
   assign rd_acc   = rd_req & ~empty_q & (cnt_q != '0);
   assign rword    = mem_q[rptr_q];
   assign wdata    = {parity_gen_en_i ? par_of(link.wr_data_in[PAR_BIT-1:0], odd_parity_sel_i)
                                      : link.wr_data_in[PAR_BIT],
                      link.wr_data_in[PAR_BIT-1:0]};

   // array is never cleared by reset
   always_ff @(posedge clk_i) begin
      if (wr_acc) begin
         mem_q[wptr_q] <= wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         if (wr_acc) begin
            wptr_q <= (wptr_q + AW'(1)) & ptr_mask;
         end
         if (rd_acc) begin
            rptr_q <= (rptr_q + AW'(1)) & ptr_mask;
         end
         cnt_q <= cnt_q + CW'(wr_acc) - CW'(rd_acc);
      end
   end

   // ----------------------------------------------------------------
   // read data and parity checks
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rdata_q;
   logic              rpe_q;
   logic              wpe_q;

   always_ff @(posedge clk_i) begin
      if (rst) begin
         rdata_q <= '0;
         rpe_q   <= 1'b0;
      end else if (rd_acc) begin
         rdata_q <= rword;
         rpe_q   <= rword[PAR_BIT] != par_of(rword[PAR_BIT-1:0], odd_parity_sel_i);
      end
   end

   // meaningless while generation is on
   always_ff @(posedge clk_i) begin
      if (rst) begin
         wpe_q <= 1'b0;
      end else if (wr_req) begin
         wpe_q <= link.wr_data_in[PAR_BIT] != par_of(link.wr_data_in[PAR_BIT-1:0], odd_parity_sel_i);
      end
   end

   // ----------------------------------------------------------------
   // flags, refreshed on a falling strobe clock
   // ----------------------------------------------------------------
   logic          eq_q;
   logic          ge_q;
   logic [CW-1:0] tgt;

   assign tgt = level_tgt(depth_log_sel_i, level_i);

   always_ff @(posedge clk_i) begin
      if (rst) begin
         full_q  <= 1'b0;
         empty_q <= 1'b1;
         eq_q    <= 1'b0;
         ge_q    <= 1'b0;
      end else if (wr_fall | rd_fall) begin
         full_q  <= cnt_q == depth;
         empty_q <= cnt_q == '0;
         eq_q    <= cnt_q == tgt;
         ge_q    <= cnt_q >= tgt;
      end
   end

   assign link.full               = full_q;
   assign link.empty              = empty_q;
   assign link.level_equal_flag   = eq_q;
   assign link.level_reached_flag = ge_q;
   assign link.rd_data_out        = rdata_q;
   assign link.rd_parity_err      = rpe_q;
   assign link.wr_parity_err      = wpe_q;
endmodule // dcf_fifo_dev

`default_nettype wire

// *** logic/dcf_fifo_user.sv ***
// user-side controller driving the fifo cell from a register port
`default_nettype none

module dcf_fifo_user
   import dcf_pkg::*;
#(
   parameter int HALF = dcf_pkg::LINK_HALF_CYC
) (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   // register port
   input  wire logic [dcf_pkg::REG_AW-1:0]  addr_i,
   input  wire logic [dcf_pkg::REG_DW-1:0]  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [dcf_pkg::REG_DW-1:0]  rdata_o,
   output logic                             irq_o,
   // link to fifo cell
   dcf_link_if.user                         link
);
   import dcf_pkg::*;

   // ----------------------------------------------------------------
   // strobe clock divider, shared by both sides
   // ----------------------------------------------------------------
   logic [7:0] div_q;
   logic       lclk_q;
   logic       tick;
   logic       fall_tick;

   assign tick      = div_q == 8'(HALF - 1);
   assign fall_tick = tick & lclk_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         div_q  <= '0;
         lclk_q <= 1'b0;
      end else begin
         div_q  <= tick ? '0 : div_q + 8'h01;
         lclk_q <= tick ? ~lclk_q : lclk_q;
      end
   end

   // ----------------------------------------------------------------
   // transfer sequencer
   // ----------------------------------------------------------------
   logic               wr_ctrl;
   logic               wr_pend_q;
   logic               rd_pend_q;
   logic               prst_n_q;
   logic [DATA_W-1:0]  wdat_q;
   logic [DATA_W-1:0]  rdat_q;
   logic               wsel_n_q;
   logic               rsel_n_q;
   logic               rpe_seen_q;
   logic               wr_done;
   logic               rd_done;
   dcf_state_t         state_q;

   assign wr_ctrl = wr_i & (addr_i == OFS_CTRL);
   assign wr_done = fall_tick & (state_q == DCF_WR);
   assign rd_done = fall_tick & (state_q == DCF_RD);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q  <= DCF_IDLE;
         wsel_n_q <= 1'b1;
         rsel_n_q <= 1'b1;
      end else if (fall_tick) begin
         unique case (state_q)
            DCF_IDLE: begin
               if (wr_pend_q & ~link.full) begin
                  wsel_n_q <= 1'b0;
                  state_q  <= DCF_WR;
               end else if (rd_pend_q & ~link.empty) begin
                  rsel_n_q <= 1'b0;
                  state_q  <= DCF_RD;
               end
            end
            DCF_WR: begin
               wsel_n_q <= 1'b1;
               state_q  <= DCF_IDLE;
            end
            DCF_RD: begin
               rsel_n_q <= 1'b1;
               state_q  <= DCF_IDLE;
            end
         endcase
      end
   end

   // a new request wins over the start that consumes the old one
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else begin
         wr_pend_q <= (wr_ctrl & wdata_i[CTRL_WR_GO]) |
                      (wr_pend_q & ~(fall_tick & (state_q == DCF_IDLE) & ~link.full));
         rd_pend_q <= (wr_ctrl & wdata_i[CTRL_RD_GO]) |
                      (rd_pend_q & ~(fall_tick & (state_q == DCF_IDLE) & ~(wr_pend_q & ~link.full)
                                     & ~link.empty));
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prst_n_q <= 1'b1;
      end else begin
         prst_n_q <= ~(wr_ctrl & wdata_i[CTRL_PRST]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wdat_q <= '0;
      end else if (wr_i & (addr_i == OFS_WDATA)) begin
         wdat_q <= wdata_i[DATA_W-1:0];
      end
   end

   // read data and parity error are sampled only at the end of a read high phase
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdat_q     <= '0;
         rpe_seen_q <= 1'b0;
      end else if (rd_done) begin
         rdat_q     <= link.rd_data_out;
         rpe_seen_q <= link.rd_parity_err;
      end
   end

   assign link.wr_side_clk    = lclk_q;
   assign link.rd_side_clk    = lclk_q;
   assign link.wr_block_sel_n = wsel_n_q;
   assign link.wr_strobe_n    = wsel_n_q;
   assign link.wr_data_in     = wdat_q;
   assign link.rd_block_sel_n = rsel_n_q;
   assign link.rd_strobe_n    = rsel_n_q;
   assign link.fifo_reset_n   = prst_n_q;

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] stat_d;
   logic [IRQ_W-1:0] mask_d;
   logic             full_prev_q;

   always_comb begin
      ev                = '0;
      ev[IRQ_WR_DONE]   = wr_done;
      ev[IRQ_RD_DONE]   = rd_done;
      ev[IRQ_RD_PAR]    = rd_done & link.rd_parity_err;
      ev[IRQ_FULL]      = link.full & ~full_prev_q;
      stat_d            = stat_q;
      if (wr_i & (addr_i == OFS_IRQ_STAT)) begin
         stat_d = stat_q & ~wdata_i[IRQ_W-1:0];
      end
      stat_d = stat_d | ev;
      mask_d = mask_q;
      if (wr_i & (addr_i == OFS_IRQ_MASK)) begin
         mask_d = wdata_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stat_q      <= '0;
         mask_q      <= IRQ_MASK_RST;
         full_prev_q <= 1'b0;
         irq_o       <= 1'b0;
      end else begin
         stat_q      <= stat_d;
         full_prev_q <= link.full;
         irq_o       <= |(stat_d & mask_d);
         mask_q      <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= '0;
         unique case (addr_i)
            OFS_CTRL:     rdata_o <= REG_DW'({rd_pend_q, wr_pend_q});
            OFS_WDATA:    rdata_o <= REG_DW'(wdat_q);
            OFS_RDATA:    rdata_o <= REG_DW'(rdat_q);
            OFS_STATUS:   rdata_o <= REG_DW'({state_q == DCF_RD, state_q == DCF_WR, link.wr_parity_err,
                                              rpe_seen_q, link.level_reached_flag, link.level_equal_flag,
                                              link.empty, link.full});
            OFS_IRQ_STAT: rdata_o <= REG_DW'(stat_q);
            OFS_IRQ_MASK: rdata_o <= REG_DW'(mask_q);
            default:      rdata_o <= '0;
         endcase
      end
   end
endmodule // dcf_fifo_user

`default_nettype wire

// *** testbench/dcf_link_chk.sv ***
// concurrent checks on the link between the two fifo ends
`default_nettype none

module dcf_link_chk
   import dcf_pkg::*;
(
   // clock and reset
   input wire logic                       clk_i,
   input wire logic                       reset_i,
   // link signals
   input wire logic                       wr_side_clk,
   input wire logic                       rd_side_clk,
   input wire logic                       wr_block_sel_n,
   input wire logic                       wr_strobe_n,
   input wire logic [dcf_pkg::DATA_W-1:0] wr_data_in,
   input wire logic                       rd_block_sel_n,
   input wire logic                       rd_strobe_n,
   input wire logic                       fifo_reset_n,
   input wire logic                       full,
   input wire logic                       empty,
   input wire logic                       level_equal_flag,
   input wire logic                       level_reached_flag,
   input wire logic [dcf_pkg::DATA_W-1:0] rd_data_out,
   input wire logic                       rd_parity_err,
   input wire logic                       wr_parity_err
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_reset_clear;
      $fell(reset_i) |-> empty && !full && !level_equal_flag && !level_reached_flag && rd_data_out == '0
         && !rd_parity_err && !wr_parity_err;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("flags or data not cleared by reset");

   property p_ptr_reset;
      !fifo_reset_n |=> empty && !full && rd_data_out == '0;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset) else $error("pointer reset did not empty the fifo");

   property p_wr_pair;
      wr_block_sel_n == wr_strobe_n;
   endproperty
   a_wr_pair: assert property (p_wr_pair) else $error("write select and strobe differ");

   property p_rd_pair;
      rd_block_sel_n == rd_strobe_n;
   endproperty
   a_rd_pair: assert property (p_rd_pair) else $error("read select and strobe differ");

   property p_same_clk;
      wr_side_clk == rd_side_clk;
   endproperty
   a_same_clk: assert property (p_same_clk) else $error("strobe clocks differ");

   property p_wr_setup;
      $rose(wr_side_clk) && !wr_strobe_n |-> $stable(wr_strobe_n) && $stable(wr_data_in);
   endproperty
   a_wr_setup: assert property (p_wr_setup) else $error("write request moved at clock rise");

   property p_wr_hold;
      $fell(wr_strobe_n) |=> (!wr_strobe_n && $stable(wr_data_in)) [*7];
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write request not held a strobe period");

   property p_flag_edge;
      $past(fifo_reset_n) && !$past(reset_i) && ($changed(full) || $changed(empty) || $changed(level_reached_flag))
         |-> $past(wr_side_clk, 2) && !$past(wr_side_clk);
   endproperty
   a_flag_edge: assert property (p_flag_edge) else $error("flag moved away from strobe clock fall");

   property p_empty_no_read;
      $past(empty, 2) && $past(fifo_reset_n) && !$past(reset_i) |-> $stable(rd_data_out) && $stable(rd_parity_err);
   endproperty
   a_empty_no_read: assert property (p_empty_no_read) else $error("read taken while empty");

   property p_level_order;
      level_equal_flag |-> level_reached_flag;
   endproperty
   a_level_order: assert property (p_level_order) else $error("equal flag without reached flag");

   property p_full_empty;
      !(full && empty);
   endproperty
   a_full_empty: assert property (p_full_empty) else $error("full and empty together");
endmodule // dcf_link_chk

`default_nettype wire

// *** testbench/dual_clock_fifo_block_tb_top.sv ***
// self-checking bench for the fifo cell and its controller
`default_nettype none

module dual_clock_fifo_block_tb_top import dcf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk_i, reset_i, wr_i, rd_i, irq_o, par_gen, par_odd;
   logic [REG_AW-1:0]      addr_i;
   logic [REG_DW-1:0]      wdata_i, rdata_o;
   logic [DEPTH_LOG_W-1:0] dep_sel;
   logic [LEVEL_W-1:0]     level;
   logic [31:0]            seed;
   logic [DATA_W-1:0]      mq[$];
   int                     fails, checks;

   dcf_link_if lnk ();
   dcf_fifo_dev #(.DLW(DEPTH_LOG_W)) dcf_fifo_dev_i (.clk_i(clk_i), .reset_i(reset_i), .link(lnk),
      .depth_log_sel_i(dep_sel), .level_i(level), .parity_gen_en_i(par_gen), .odd_parity_sel_i(par_odd));
   dcf_fifo_user #(.HALF(4)) dcf_fifo_user_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(lnk));
   dcf_link_chk dcf_link_chk_i (.clk_i(clk_i), .reset_i(reset_i), .wr_side_clk(lnk.wr_side_clk),
      .rd_side_clk(lnk.rd_side_clk), .wr_block_sel_n(lnk.wr_block_sel_n), .wr_strobe_n(lnk.wr_strobe_n),
      .wr_data_in(lnk.wr_data_in), .rd_block_sel_n(lnk.rd_block_sel_n), .rd_strobe_n(lnk.rd_strobe_n),
      .fifo_reset_n(lnk.fifo_reset_n), .full(lnk.full), .empty(lnk.empty),
      .level_equal_flag(lnk.level_equal_flag), .level_reached_flag(lnk.level_reached_flag),
      .rd_data_out(lnk.rd_data_out), .rd_parity_err(lnk.rd_parity_err), .wr_parity_err(lnk.wr_parity_err));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic note_fail(input string m);
      fails++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
         note_fail($sformatf("value %h expected %h", got, exp));
   endtask

   task automatic chk_flags(input logic [15:0] st, input int n, input int dep);
      logic [3:0] e;
      e = {n >= level, n == level, n == 0, n == dep};
      checks++;
      if (st[ST_GE:ST_FULL] !== e)
         note_fail($sformatf("flags %b expected %b at count %0d", st[ST_GE:ST_FULL], e, n));
   endtask

   task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask

   task automatic run_op(input int b, output logic [15:0] st);
      logic [15:0] c;
      int          i;
      reg_wr(OFS_CTRL, 16'h1 << b);
      for (i = 0; i < 40; i++) begin
         reg_rd(OFS_CTRL, c);
         reg_rd(OFS_STATUS, st);
         if (c[1:0] === 2'b00 && st[ST_RBUSY:ST_WBUSY] === 2'b00)
            break;
      end
      if (i == 40) begin
         note_fail("transfer never completed");
         print_verdict();
      end
      reg_rd(OFS_STATUS, st);
   endtask

   // request that the controller must hold back, left pending
   task automatic refuse(input int b, output logic [15:0] st);
      logic [15:0] c;
      reg_wr(OFS_CTRL, 16'h1 << b);
      repeat (24) @(posedge clk_i);
      reg_rd(OFS_CTRL, c);
      chk_word(c[b], 1'b1);
      reg_rd(OFS_STATUS, st);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] st, d;
      logic [8:0]  w;
      logic [8:0]  wp;
      logic        p;
      int          dep;
      {fails, checks, addr_i, wdata_i, wr_i, rd_i, dep_sel, level, par_gen, par_odd} = '0;
      reset_i = 1'b1;
      seed = 32'h8def52f3;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      reg_rd(OFS_STATUS, st);
      chk_word(st[ST_EMPTY:ST_FULL], 2'b10);
      reg_rd(4'hf, d);
      chk_word(d, 16'h0);
      reg_rd(OFS_IRQ_MASK, d);
      chk_word(d, 16'(IRQ_MASK_RST));
      $display("test reset done");
      for (int f = 0; f < 8; f++) begin
         dep = 2 << f;
         seed = lfsr(seed);
         @(posedge clk_i);
         dep_sel <= f[2:0];
         level <= 8'(seed % (dep + 1));
         reg_wr(OFS_CTRL, 16'h1 << CTRL_PRST);
         for (int k = 0; k <= dep; k++) begin
            seed = lfsr(seed);
            w = seed[8:0];
            reg_wr(OFS_WDATA, {7'h0, w});
            if (k < dep) begin
               run_op(CTRL_WR_GO, st);
               mq.push_back(w);
            end else begin
               refuse(CTRL_WR_GO, st);
               wp = w;
            end
            chk_flags(st, mq.size(), dep);
         end
         for (int k = 0; k <= dep; k++) begin
            if (mq.size() > 0)
               w = mq.pop_front();
            run_op(CTRL_RD_GO, st);
            if (k == 0)
               mq.push_back(wp);
            chk_flags(st, mq.size(), dep);
            reg_rd(OFS_RDATA, d);
            chk_word(d, {7'h0, w});
         end
      end
      $display("test depth done");
      for (int m = 0; m < 4; m++) begin
         seed = lfsr(seed);
         @(posedge clk_i);
         par_gen <= m[1];
         par_odd <= m[0];
         p = ^seed[7:0] ^ m[0];
         w = {p ^ m[0], seed[7:0]};
         reg_wr(OFS_WDATA, {7'h0, w});
         run_op(CTRL_WR_GO, st);
         if (!m[1])
            chk_word(st[ST_WPE], m[0]);
         run_op(CTRL_RD_GO, st);
         chk_word(st[ST_RPE], m[1] ? 1'b0 : m[0]);
         reg_rd(OFS_RDATA, d);
         chk_word(d, {7'h0, m[1] ? p : w[8], w[7:0]});
      end
      $display("test parity done");
      reg_wr(OFS_IRQ_STAT, 16'hf);
      reg_wr(OFS_IRQ_MASK, 16'h1 << IRQ_WR_DONE);
      reg_wr(OFS_WDATA, 16'h0);
      run_op(CTRL_WR_GO, st);
      chk_word(irq_o, 1'b1);
      reg_rd(OFS_IRQ_STAT, d);
      chk_word(d[IRQ_WR_DONE], 1'b1);
      reg_wr(OFS_IRQ_MASK, 16'h0);
      @(negedge clk_i);
      chk_word(irq_o, 1'b0);
      reg_wr(OFS_IRQ_MASK, 16'h1 << IRQ_WR_DONE);
      @(negedge clk_i);
      chk_word(irq_o, 1'b1);
      reg_wr(OFS_IRQ_STAT, 16'h1 << IRQ_WR_DONE);
      @(negedge clk_i);
      chk_word(irq_o, 1'b0);
      $display("test irq done");
      reg_wr(OFS_CTRL, 16'h1 << CTRL_PRST);
      reg_rd(OFS_STATUS, st);
      chk_word(st[ST_EMPTY:ST_FULL], 2'b10);
      refuse(CTRL_RD_GO, st);
      chk_word(st[ST_EMPTY:ST_FULL], 2'b10);
      reg_rd(OFS_RDATA, d);
      chk_word(d, {7'h0, p, w[7:0]});
      $display("test pointer reset done");
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      reg_rd(OFS_STATUS, st);
      chk_word(st[ST_EMPTY:ST_FULL], 2'b10);
      chk_word(irq_o, 1'b0);
      $display("test second reset done");
      print_verdict();
   end
endmodule // dual_clock_fifo_block_tb_top

`default_nettype wire
